// >>> design/bitbang_pkg.sv
// Purpose: constants shared by the bit-banged serial pin ports
// Assumes: long accesses only; address alone selects the action
// Notes:   line and sense vectors are indexed by the positions below
package bitbang_pkg;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [31:0] EE_CLOCK_LOW_OFS        = 32'hf000_0000;
    localparam logic [31:0] EE_CLOCK_HIGH_OFS       = 32'hf040_0000;
    localparam logic [31:0] EE_DATA_LOW_SENSE_OFS   = 32'hf080_0000;
    localparam logic [31:0] EE_DATA_HIGH_OFS        = 32'hf0c0_0000;
    localparam logic [31:0] SEN_SEL_RELEASE_OFS     = 32'hf100_0000;
    localparam logic [31:0] SEN_SEL_ASSERT_OFS      = 32'hf140_0000;
    localparam logic [31:0] SEN_CLOCK_LOW_OFS       = 32'hf180_0000;
    localparam logic [31:0] SEN_CLOCK_HIGH_OFS      = 32'hf1c0_0000;
    // address bits that take part in the decode
    localparam logic [31:0] DECODE_MASK             = 32'hffc0_0000;

    // ==================================================================
    // access size code for a long word
    localparam logic [1:0]  SIZE_LONG               = 2'h0;
    // data bus bit that carries a sensed line
    localparam int          READ_DATA_BIT           = 0;

    // ==================================================================
    // output line positions and their levels after reset
    localparam int          LINE_EE_CLK             = 0;
    localparam int          LINE_EE_DATA            = 1;
    localparam int          LINE_SEN_SEL            = 2;
    localparam int          LINE_SEN_CLK            = 3;
    localparam int          LINE_COUNT              = 4;
    // idle: eeprom clock and data high, select released, clock low
    localparam logic [3:0]  LINES_RESET             = 4'h7;

    // ==================================================================
    // sensed input positions and their synchroniser reset value
    localparam int          SENSE_EE_DATA           = 0;
    localparam int          SENSE_SEN_DATA          = 1;
    localparam int          SENSE_COUNT             = 2;
    localparam logic [1:0]  SENSE_RESET             = 2'h0;

endpackage

// >>> design/level_sync.sv
// Purpose: two-flop synchroniser for a group of slow levels
// Assumes: each bit is an independent level, no word coherence
// Notes:   first stage feeds the second stage and nothing else
`timescale 1ns/10ps
module level_sync #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset of the receiving domain
    input  wire logic clk,
    input  wire logic rstn,
    // levels in and out
    level_sync_if.sync port
);

    // ==================================================================
    // elaboration checks
    if (WIDTH < 1) begin : g_bad_width
        $error("level_sync: WIDTH must be at least 1");
    end
    if ($bits(port.async) != WIDTH) begin : g_bad_port
        $error("level_sync: interface width differs from WIDTH");
    end

    // ==================================================================
    // state
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_type;

    sync_state_type stateQ;
    sync_state_type stateD;

    always_comb begin
        stateD        = stateQ;
        stateD.first  = port.async;
        stateD.second = stateQ.first;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stateQ <= {RESET_VALUE, RESET_VALUE};
        end else begin
            stateQ <= stateD;
        end
    end

    assign port.synced = stateQ.second;

endmodule

// >>> design/level_sync_if.sv
// Purpose: carries a group of levels into a two-flop synchroniser
// Assumes: levels change slowly compared to the receiving clock
// Notes:   one instance per crossing
`timescale 1ns/10ps
interface level_sync_if #(
    parameter int WIDTH = 1
);
    logic [WIDTH-1:0] async;
    logic [WIDTH-1:0] synced;

    modport source (output async);
    modport sync   (input  async, output synced);
    modport sink   (input  synced);
endinterface

// >>> design/serial_pin_ports.sv
// Purpose: address-decoded pin ports for bit-banged eeprom and sensor
// Assumes: processor makes every waveform; one request per strobe
// Notes:   pin-facing flops run on linkClk; all crossings are levels
`timescale 1ns/10ps

// Behaviour
// - long write at select-release offset raises select; assert offset lowers it
// - long writes set sensor clock low or high; level held until next write
// - long read at select-release offset returns sensor data on bit 0
// - long writes at eeprom clock offsets drive eeprom clock low or high
// - long writes set eeprom data 0 or 1; read returns sensed data bit 0
module serial_pin_ports (
    // system clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // link clock for the pin-facing flops
    input  wire logic        linkClk,
    // processor register port
    input  wire logic        busReq,
    input  wire logic        busWrite,
    input  wire logic [1:0]  busSize,
    input  wire logic [31:0] busAddr,
    output logic             busAck,
    output logic [31:0]      busRdata,
    // eeprom two-wire pins
    output logic             eeClk,
    input  wire logic        eeDataIn,
    output logic             eeDataOut,
    output logic             eeDataOeN,
    // temperature converter pins
    output logic             sensorSelect,
    output logic             sensorClk,
    input  wire logic        sensorDataPort
);

    // ==================================================================
    // decode helper
    function automatic logic hitReg(input logic [31:0] addr,
                                    input logic [31:0] offset);
        hitReg = (addr & bitbang_pkg::DECODE_MASK) == offset;
    endfunction

    // ==================================================================
    // crossings
    level_sync_if #(.WIDTH(bitbang_pkg::LINE_COUNT))  ctlSync ();
    level_sync_if #(.WIDTH(bitbang_pkg::SENSE_COUNT)) pinSync ();
    level_sync_if #(.WIDTH(bitbang_pkg::SENSE_COUNT)) backSync ();

    // line levels into the link domain
    level_sync #(
        .WIDTH       (bitbang_pkg::LINE_COUNT),
        .RESET_VALUE (bitbang_pkg::LINES_RESET)
    ) ctlSyncInst (
        .clk  (linkClk),
        .rstn (rstn),
        .port (ctlSync)
    );

    // pins into the link domain
    level_sync #(
        .WIDTH       (bitbang_pkg::SENSE_COUNT),
        .RESET_VALUE (bitbang_pkg::SENSE_RESET)
    ) pinSyncInst (
        .clk  (linkClk),
        .rstn (rstn),
        .port (pinSync)
    );

    // sensed levels back to the bus domain
    level_sync #(
        .WIDTH       (bitbang_pkg::SENSE_COUNT),
        .RESET_VALUE (bitbang_pkg::SENSE_RESET)
    ) backSyncInst (
        .clk  (clk),
        .rstn (rstn),
        .port (backSync)
    );

    // ==================================================================
    // bus domain state
    typedef struct packed {
        logic [bitbang_pkg::LINE_COUNT-1:0] lines;
        logic                               ack;
        logic [31:0]                        rdata;
    } bus_state_type;

    bus_state_type busQ;
    bus_state_type busD;

    always_comb begin
        busD     = busQ;
        busD.ack = 1'b0;
        if (busReq) begin
            // every request is answered; unmapped or short reads give zero
            busD.ack   = 1'b1;
            busD.rdata = '0;
            if (busSize == bitbang_pkg::SIZE_LONG && busWrite) begin
                // address alone picks the level, data is not looked at
                if (hitReg(busAddr, bitbang_pkg::EE_CLOCK_LOW_OFS)) begin
                    busD.lines[bitbang_pkg::LINE_EE_CLK] = 1'b0;
                end
                if (hitReg(busAddr, bitbang_pkg::EE_CLOCK_HIGH_OFS)) begin
                    busD.lines[bitbang_pkg::LINE_EE_CLK] = 1'b1;
                end
                if (hitReg(busAddr,
                           bitbang_pkg::EE_DATA_LOW_SENSE_OFS)) begin
                    busD.lines[bitbang_pkg::LINE_EE_DATA] = 1'b0;
                end
                if (hitReg(busAddr, bitbang_pkg::EE_DATA_HIGH_OFS)) begin
                    busD.lines[bitbang_pkg::LINE_EE_DATA] = 1'b1;
                end
                if (hitReg(busAddr, bitbang_pkg::SEN_SEL_RELEASE_OFS)) begin
                    busD.lines[bitbang_pkg::LINE_SEN_SEL] = 1'b1;
                end
                if (hitReg(busAddr, bitbang_pkg::SEN_SEL_ASSERT_OFS)) begin
                    busD.lines[bitbang_pkg::LINE_SEN_SEL] = 1'b0;
                end
                if (hitReg(busAddr, bitbang_pkg::SEN_CLOCK_LOW_OFS)) begin
                    busD.lines[bitbang_pkg::LINE_SEN_CLK] = 1'b0;
                end
                if (hitReg(busAddr, bitbang_pkg::SEN_CLOCK_HIGH_OFS)) begin
                    busD.lines[bitbang_pkg::LINE_SEN_CLK] = 1'b1;
                end
            end else if (busSize == bitbang_pkg::SIZE_LONG) begin
                // sensed levels lag the pins by the two crossings
                if (hitReg(busAddr,
                           bitbang_pkg::EE_DATA_LOW_SENSE_OFS)) begin
                    busD.rdata[bitbang_pkg::READ_DATA_BIT] =
                        backSync.synced[bitbang_pkg::SENSE_EE_DATA];
                end
                if (hitReg(busAddr, bitbang_pkg::SEN_SEL_RELEASE_OFS)) begin
                    busD.rdata[bitbang_pkg::READ_DATA_BIT] =
                        backSync.synced[bitbang_pkg::SENSE_SEN_DATA];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busQ <= '{lines: bitbang_pkg::LINES_RESET,
                      ack:   1'b0,
                      rdata: 32'h0000_0000};
        end else begin
            busQ <= busD;
        end
    end

    assign busAck        = busQ.ack;
    assign busRdata      = busQ.rdata;
    assign ctlSync.async = busQ.lines;

    // ==================================================================
    // link domain state, the pins themselves
    typedef struct packed {
        logic eeClk;
        logic eeDataOut;
        logic eeDataOeN;
        logic sensorSelect;
        logic sensorClk;
        logic [bitbang_pkg::SENSE_COUNT-1:0] sense;
    } link_state_type;

    link_state_type linkQ;
    link_state_type linkD;

    always_comb begin
        linkD              = linkQ;
        linkD.eeClk        = ctlSync.synced[bitbang_pkg::LINE_EE_CLK];
        // open drain: a one releases the line, a zero pulls it down
        linkD.eeDataOut    = 1'b0;
        linkD.eeDataOeN    = ctlSync.synced[bitbang_pkg::LINE_EE_DATA];
        linkD.sensorSelect = ctlSync.synced[bitbang_pkg::LINE_SEN_SEL];
        linkD.sensorClk    = ctlSync.synced[bitbang_pkg::LINE_SEN_CLK];
        // registered in the link domain so the return crossing sees one source
        linkD.sense        = pinSync.synced;
    end

    always_ff @(posedge linkClk or negedge rstn) begin
        if (!rstn) begin
            linkQ <= '{eeClk:        bitbang_pkg::LINES_RESET[
                                         bitbang_pkg::LINE_EE_CLK],
                       eeDataOut:    1'b0,
                       eeDataOeN:    bitbang_pkg::LINES_RESET[
                                         bitbang_pkg::LINE_EE_DATA],
                       sensorSelect: bitbang_pkg::LINES_RESET[
                                         bitbang_pkg::LINE_SEN_SEL],
                       sensorClk:    bitbang_pkg::LINES_RESET[
                                         bitbang_pkg::LINE_SEN_CLK],
                       sense:        bitbang_pkg::SENSE_RESET};
        end else begin
            linkQ <= linkD;
        end
    end

    assign pinSync.async  = {sensorDataPort, eeDataIn};
    assign backSync.async = linkQ.sense;

    assign eeClk        = linkQ.eeClk;
    assign eeDataOut    = linkQ.eeDataOut;
    assign eeDataOeN    = linkQ.eeDataOeN;
    assign sensorSelect = linkQ.sensorSelect;
    assign sensorClk    = linkQ.sensorClk;

endmodule

// >>> dv/serial_partner.sv
// Purpose: eeprom and converter model at the far side of the pins
// Assumes: eeprom data wire has a pull-up; converter shifts on clock rise
// Notes:   eeprom returns word address xor ROM_MASK
`timescale 1ns/10ps
module serial_partner #(
    parameter logic [7:0] ROM_MASK    = 8'h5a,
    parameter logic [7:0] SENSOR_BYTE = 8'hc3
) (
    // eeprom wire and pull-down
    input  wire logic eeClk,
    input  wire logic eeDataIn,
    output logic      eePull,
    // converter
    input  wire logic sensorSelect,
    input  wire logic sensorClk,
    output logic      sensorDataPort
);
    logic [3:0] bitNo = 4'h0;
    logic [7:0] sh = 8'h0;
    logic [7:0] wordAddr = 8'h0;
    logic [2:0] senBit = 3'h0;
    logic       sending = 1'b0;
    logic       first = 1'b0;
    logic       readReq = 1'b0;
    wire  [7:0] romByte = wordAddr ^ ROM_MASK;
    initial eePull = 1'b0;
    initial sensorDataPort = 1'b0;
    always @(negedge eeDataIn) if (eeClk) begin // start
        bitNo = 4'h0;
        sending = 1'b0;
        first = 1'b1;
    end
    always @(posedge eeDataIn) if (eeClk) sending = 1'b0; // stop
    always @(posedge eeClk) begin // sampled on rise
        sh = {sh[6:0], eeDataIn};
        bitNo = bitNo + 4'h1;
    end
    always @(negedge eeClk) begin
        if (sending) begin // msb first, released for no ack
            eePull = bitNo < 4'h8 && !romByte[3'h7 - bitNo[2:0]];
        end else if (bitNo == 4'h8) begin
            eePull = !first || sh[7:1] == 7'h50;
            readReq = first && sh == 8'ha1;
            if (!first) wordAddr = sh;
            first = 1'b0;
        end else if (bitNo == 4'h9) begin
            bitNo = 4'h0;
            sending = readReq;
            eePull = readReq && !romByte[7];
        end
    end
    always @(negedge sensorSelect) senBit = 3'h0;
    always @(posedge sensorClk) if (!sensorSelect) begin
        sensorDataPort = SENSOR_BYTE[3'h7 - senBit];
        senBit = senBit + 3'h1;
    end
    // released output must not look like data
    always @(posedge sensorSelect) sensorDataPort = ~sensorDataPort;
endmodule

// >>> dv/serial_pin_ports_properties.sv
// Purpose: port assertions for serial_pin_ports
// Assumes: writes to one line are spaced over 130 clk cycles
// Notes:   pin delay bound covers the link clock crossing
`timescale 1ns/10ps
module serial_pin_ports_properties (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // register port
    input wire logic        busReq,
    input wire logic        busWrite,
    input wire logic [1:0]  busSize,
    input wire logic [31:0] busAddr,
    input wire logic        busAck,
    input wire logic [31:0] busRdata,
    // pins
    input wire logic        eeClk,
    input wire logic        eeDataOeN,
    input wire logic        sensorSelect,
    input wire logic        sensorClk
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    function automatic logic hit(input logic [31:0] o);
        return busReq && busWrite && busSize == bitbang_pkg::SIZE_LONG
            && (busAddr & bitbang_pkg::DECODE_MASK) == o;
    endfunction
    // ====
    // bus answer
    a_ack_next: assert property (busReq |=> busAck)
        else $error("no ack");
    a_rdata_upper: assert property (busAck |-> busRdata[31:1] == 31'h0)
        else $error("rdata upper bits");
    // ====
    // pins follow their write within 130 clk cycles, about four link periods
    a_ee_clk_low: assert property (hit(bitbang_pkg::EE_CLOCK_LOW_OFS)
        |-> ##[1:130] !eeClk) else $error("ee clock low");
    a_ee_clk_high: assert property (hit(bitbang_pkg::EE_CLOCK_HIGH_OFS)
        |-> ##[1:130] eeClk) else $error("ee clock high");
    a_ee_data_low: assert property (
        hit(bitbang_pkg::EE_DATA_LOW_SENSE_OFS) |-> ##[1:130] !eeDataOeN)
        else $error("ee data low");
    a_ee_data_high: assert property (hit(bitbang_pkg::EE_DATA_HIGH_OFS)
        |-> ##[1:130] eeDataOeN) else $error("ee data high");
    a_sel_release: assert property (
        hit(bitbang_pkg::SEN_SEL_RELEASE_OFS) |-> ##[1:130] sensorSelect)
        else $error("select release");
    a_sel_assert: assert property (
        hit(bitbang_pkg::SEN_SEL_ASSERT_OFS) |-> ##[1:130] !sensorSelect)
        else $error("select assert");
    a_sen_clk_low: assert property (hit(bitbang_pkg::SEN_CLOCK_LOW_OFS)
        |-> ##[1:130] !sensorClk) else $error("sensor clock low");
    a_sen_clk_high: assert property (
        hit(bitbang_pkg::SEN_CLOCK_HIGH_OFS) |-> ##[1:130] sensorClk)
        else $error("sensor clock high");
    cover property (hit(bitbang_pkg::SEN_SEL_ASSERT_OFS));
    cover property (busAck && busRdata[0]);
    cover property ($fell(eeDataOeN) && eeClk);
endmodule
bind serial_pin_ports serial_pin_ports_properties i_props (.clk, .rstn,
    .busReq, .busWrite, .busSize, .busAddr, .busAck, .busRdata, .eeClk,
    .eeDataOeN, .sensorSelect, .sensorClk);

// >>> dv/tb.sv
// Purpose: self-checking bench for serial_pin_ports
// Assumes: partner model stands for eeprom and converter
// Notes:   accesses spaced 200 clk so pins settle across the link clock
`timescale 1ns/10ps
module tb;
    logic        clk = 1'b0;
    logic        linkClk = 1'b0;
    logic        rstn = 1'b0;
    logic        busReq = 1'b0;
    logic        busWrite = 1'b0;
    logic [1:0]  busSize = 2'h0;
    logic [31:0] busAddr = 32'h0;
    logic [31:0] busRdata;
    logic        busAck, eeClk, eeDataOut, eeDataOeN, eePull;
    logic        sensorSelect, sensorClk, sensorDataPort;
    wire         eeDataIn = !(eeDataOeN === 1'b0 || eePull);
    int          failCount = 0;
    int          testsRun = 0;
    int          cycles = 0;
    always #2.5 clk = ~clk;
    initial #1.3 forever #80 linkClk = ~linkClk;
    serial_pin_ports i_serial_pin_ports (.clk, .rstn, .linkClk, .busReq,
        .busWrite, .busSize, .busAddr, .busAck, .busRdata, .eeClk,
        .eeDataIn, .eeDataOut, .eeDataOeN, .sensorSelect, .sensorClk,
        .sensorDataPort);
    serial_partner i_serial_partner (.eeClk, .eeDataIn, .eePull,
        .sensorSelect, .sensorClk, .sensorDataPort);
    // ====
    // access and compare
    task automatic check(input string what, input logic [31:0] seen, exp);
        testsRun++;
        if (seen !== exp) begin
            failCount++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic access(input logic w, input logic [31:0] a,
            input logic [1:0] s, output logic [31:0] d);
        @(negedge clk);
        busReq = 1'b1;
        busWrite = w;
        busSize = s;
        busAddr = a;
        @(negedge clk);
        busReq = 1'b0;
        check("ack", busAck, 1'b1);
        d = busRdata;
        repeat (200) @(negedge clk);
    endtask
    task automatic put(input logic [31:0] a);
        logic [31:0] d;
        access(1'b1, a, bitbang_pkg::SIZE_LONG, d);
    endtask
    task automatic eeData(input logic b);
        put(b ? bitbang_pkg::EE_DATA_HIGH_OFS
            : bitbang_pkg::EE_DATA_LOW_SENSE_OFS);
    endtask
    task automatic eeClock(input logic b);
        put(b ? bitbang_pkg::EE_CLOCK_HIGH_OFS
            : bitbang_pkg::EE_CLOCK_LOW_OFS);
    endtask
    task automatic eeByte(input logic [8:0] v, output logic [8:0] r);
        logic [31:0] d;
        for (int i = 8; i >= 0; i--) begin
            eeData(v[i]); // data moves only while clock low
            eeClock(1'b1);
            access(1'b0, bitbang_pkg::EE_DATA_LOW_SENSE_OFS, 2'h0, d);
            r[i] = d[0];
            eeClock(1'b0);
        end
    endtask
    // ====
    // scenarios
    task automatic testEeprom();
        logic [8:0] r;
        eeData(1'b0); // start
        eeClock(1'b0);
        eeByte({8'ha0, 1'b1}, r);
        check("address ack", r[0], 1'b0);
        eeByte({8'h03, 1'b1}, r);
        check("word ack", r[0], 1'b0);
        eeData(1'b1); // repeated start
        eeClock(1'b1);
        eeData(1'b0);
        eeClock(1'b0);
        eeByte({8'ha1, 1'b1}, r);
        check("read ack", r[0], 1'b0);
        eeByte(9'h1ff, r);
        check("byte", r, {8'h59, 1'b1});
        eeData(1'b0); // stop
        eeClock(1'b1);
        eeData(1'b1);
        check("ee idle", {eeClk, eeDataOeN, eeDataOut}, 3'h6);
        $display("eeprom test done");
    endtask
    task automatic testSensor();
        logic [31:0] d;
        logic [7:0]  v;
        put(bitbang_pkg::SEN_SEL_ASSERT_OFS);
        check("select on", sensorSelect, 1'b0);
        for (int i = 0; i < 8; i++) begin // about 330 kHz
            put(bitbang_pkg::SEN_CLOCK_HIGH_OFS);
            access(1'b0, bitbang_pkg::SEN_SEL_RELEASE_OFS, 2'h0, d);
            check("clock held", sensorClk, 1'b1);
            v = {v[6:0], d[0]};
            put(bitbang_pkg::SEN_CLOCK_LOW_OFS);
        end
        put(bitbang_pkg::SEN_SEL_RELEASE_OFS);
        check("result", v, 8'hc3);
        check("select off", sensorSelect, 1'b1);
        $display("sensor test done");
    endtask
    task automatic testDecode();
        logic [31:0] d;
        access(1'b1, bitbang_pkg::SEN_CLOCK_HIGH_OFS, 2'h2, d);
        check("short write", sensorClk, 1'b0);
        put(32'hf1c0_0abc);
        check("alias", sensorClk, 1'b1);
        put(bitbang_pkg::SEN_CLOCK_LOW_OFS);
        access(1'b0, 32'hf200_0000, 2'h0, d);
        check("unmapped", d, 32'h0);
        // sensor data idles high here, so a short read that leaks would show
        access(1'b0, bitbang_pkg::SEN_SEL_RELEASE_OFS, 2'h1, d);
        check("short read", d, 32'h0);
        access(1'b0, bitbang_pkg::EE_CLOCK_HIGH_OFS, 2'h0, d);
        check("write only", d, 32'h0);
        $display("decode test done");
    endtask
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failCount++;
            endOfTest();
        end
    end
    initial begin
        repeat (2) @(posedge linkClk);
        @(negedge clk);
        rstn = 1'b1;
        check("reset pins", {eeClk, eeDataOut, eeDataOeN, sensorSelect,
            sensorClk}, 5'h16);
        testDecode();
        testSensor();
        testEeprom();
        endOfTest();
    end
endmodule
